// File: core/ffc_bank.sv
// Fault flag, input pin and fault response register bank.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Reading the flag register clears every flag bit not set again by an event in the same cycle.
// - Bit 0 sets on flash timeout, bit 1 on thermal shutdown.
// - Bit 2 sets on LED open or short failure.
// - Bits 3 and 4 set on sync input change; bit 3 only in sync mode.
// - Bit 5 sets when thermistor mode on and pin below trip level.
// - Bits 7 and 6 flag input and flash undervoltage, when monitors enabled.
// - Config1 bit 7 selects torch pin role; cleared after a flash pulse.
// - Config1 bits 6 and 5 set sync input polarities, default high.
// - Config1 bit 4 makes indicator pin a thermistor comparator input.
// - Config1 bit 3 sets flash trigger polarity, default active high.
// - Config2 bit 4 selects torch or shutdown on first sync event.
// - Config2 bit 0 selects torch or shutdown on second sync event.
// - Config2 bit 1 selects torch or shutdown on thermistor trip.
// - Config2 bit 3 selects torch or shutdown on input undervoltage.
// - Config2 bit 2 enables alternate external torch mode.
module ffc_bank (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Register access
    input wire ffc_pkg::ffc_req_t REQ,
    output logic [7:0] RDATA,
    // Raw conditions and monitor enables
    input wire ffc_pkg::ffc_cond_t COND,
    input wire logic INPUT_UV_MON_EN,
    input wire logic FLASH_UV_MON_EN,
    input wire logic FLASH_DONE,
    input wire logic TRIGGER_PIN,
    // Control outputs
    output logic FLASH_TRIGGER,
    output logic HW_TORCH_EN,
    output logic THERMISTOR_MODE,
    output logic ALTERNATE_EXTERNAL_TORCH,
    output logic FORCE_TORCH,
    output logic FORCE_SHUTDOWN
);
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] cfg1_reg;
    logic [7:0] cfg2_reg;
    logic [7:0] rdata_next;
    logic trig_reg;
    logic torch_reg;
    logic shdn_reg;
    logic sync1_act;
    logic sync1_chg;
    logic sync2_act;
    logic sync2_chg;
    logic [7:0] events;

    wire logic sel_flags = REQ.addr == ffc_pkg::FAULT_FLAGS_ADDR;
    wire logic sel_cfg1 = REQ.addr == ffc_pkg::INPUT_PIN_CONFIG_ADDR;
    wire logic sel_cfg2 = REQ.addr == ffc_pkg::FAULT_RESPONSE_CONFIG_ADDR;
    wire logic rd_flags = REQ.rd && sel_flags;
    wire logic sync1_mode = !cfg1_reg[ffc_pkg::CF1_HW_TORCH];
    wire logic therm_on = cfg1_reg[ffc_pkg::CF1_THERMISTOR_MODE];

    ffc_edge u_sync1 (
        .clk(CLK),
        .resetn(RESETN),
        .pin(COND.sync1_pin),
        .active_high(cfg1_reg[ffc_pkg::CF1_SYNC1_POL]),
        .active(sync1_act),
        .changed(sync1_chg)
    );

    ffc_edge u_sync2 (
        .clk(CLK),
        .resetn(RESETN),
        .pin(COND.sync2_pin),
        .active_high(cfg1_reg[ffc_pkg::CF1_SYNC2_POL]),
        .active(sync2_act),
        .changed(sync2_chg)
    );

    assign events[ffc_pkg::FLG_TIMEOUT] = COND.timeout;
    assign events[ffc_pkg::FLG_THERMAL] = COND.thermal;
    assign events[ffc_pkg::FLG_LED_FAIL] = COND.led_fail;
    assign events[ffc_pkg::FLG_SYNC1] = sync1_chg && sync1_mode;
    assign events[ffc_pkg::FLG_SYNC2] = sync2_chg;
    assign events[ffc_pkg::FLG_THERMISTOR] =
        therm_on && COND.thermistor_low;
    assign events[ffc_pkg::FLG_FLASH_UV] =
        FLASH_UV_MON_EN && COND.flash_uv;
    assign events[ffc_pkg::FLG_INPUT_UV] =
        INPUT_UV_MON_EN && COND.input_uv;

    // A new event wins over the clear of the same read.
    assign flags_next = (rd_flags ? 8'h00 : flags_reg) | events;

    // Read data is the value held before this read's clear.
    assign rdata_next = sel_flags ? flags_reg :
                        sel_cfg1 ? cfg1_reg :
                        sel_cfg2 ? cfg2_reg : 8'h00;

    wire logic trig_level =
        TRIGGER_PIN ~^ cfg1_reg[ffc_pkg::CF1_TRIG_POL];
    wire logic trig_next = cfg1_reg[ffc_pkg::CF1_TRIG_EN] && trig_level;

    // Each enabled sync, thermistor or input undervoltage condition asks for torch or shutdown by its select bit; shutdown wins.
    wire logic ev_sync1 = sync1_mode && sync1_act;
    wire logic ev_therm = therm_on && COND.thermistor_low;
    wire logic ev_uv = INPUT_UV_MON_EN && COND.input_uv;
    wire logic shdn_next =
        (ev_sync1 && cfg2_reg[ffc_pkg::CF2_SYNC1_SHDN]) ||
        (sync2_act && cfg2_reg[ffc_pkg::CF2_SYNC2_SHDN]) ||
        (ev_therm && cfg2_reg[ffc_pkg::CF2_THERM_SHDN]) ||
        (ev_uv && cfg2_reg[ffc_pkg::CF2_INPUT_UV_SHDN]);
    wire logic torch_next = !shdn_next && (
        (ev_sync1 && !cfg2_reg[ffc_pkg::CF2_SYNC1_SHDN]) ||
        (sync2_act && !cfg2_reg[ffc_pkg::CF2_SYNC2_SHDN]) ||
        (ev_therm && !cfg2_reg[ffc_pkg::CF2_THERM_SHDN]) ||
        (ev_uv && !cfg2_reg[ffc_pkg::CF2_INPUT_UV_SHDN]));

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            flags_reg <= ffc_pkg::FAULT_FLAGS_RESET;
            RDATA <= 8'h00;
        end else begin
            flags_reg <= flags_next;
            if (REQ.rd) begin
                RDATA <= rdata_next;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cfg1_reg <= ffc_pkg::INPUT_PIN_CONFIG_RESET;
        end else if (REQ.wr && sel_cfg1) begin
            cfg1_reg <= REQ.wdata & ffc_pkg::INPUT_PIN_CONFIG_MASK;
        end else if (FLASH_DONE) begin
            cfg1_reg[ffc_pkg::CF1_HW_TORCH] <= 1'h0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cfg2_reg <= ffc_pkg::FAULT_RESPONSE_CONFIG_RESET;
        end else if (REQ.wr && sel_cfg2) begin
            cfg2_reg <= REQ.wdata & ffc_pkg::FAULT_RESPONSE_CONFIG_MASK;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            trig_reg <= 1'h0;
            torch_reg <= 1'h0;
            shdn_reg <= 1'h0;
            HW_TORCH_EN <= 1'h0;
            THERMISTOR_MODE <= 1'h0;
            ALTERNATE_EXTERNAL_TORCH <= 1'h0;
        end else begin
            trig_reg <= trig_next;
            torch_reg <= torch_next;
            shdn_reg <= shdn_next;
            HW_TORCH_EN <= cfg1_reg[ffc_pkg::CF1_HW_TORCH];
            THERMISTOR_MODE <= therm_on;
            ALTERNATE_EXTERNAL_TORCH <=
                cfg2_reg[ffc_pkg::CF2_ALT_EXT_TORCH];
        end
    end

    assign FLASH_TRIGGER = trig_reg;
    assign FORCE_TORCH = torch_reg;
    assign FORCE_SHUTDOWN = shdn_reg;

    property p_read_clears;
        @(posedge CLK) disable iff (!RESETN)
        (REQ.rd && sel_flags && !(|events)) |=> flags_reg == 8'h00;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("flag register not cleared by read");

    property p_read_data;
        @(posedge CLK) disable iff (!RESETN)
        (REQ.rd && sel_flags) |=> RDATA == $past(flags_reg);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read data is not the pre-clear flag value");

    property p_event_kept;
        @(posedge CLK) disable iff (!RESETN)
        COND.timeout |=> flags_reg[ffc_pkg::FLG_TIMEOUT];
    endproperty
    a_event_kept: assert property (p_event_kept)
        else $error("timeout event lost");

    property p_led;
        @(posedge CLK) disable iff (!RESETN)
        COND.led_fail |=> flags_reg[ffc_pkg::FLG_LED_FAIL];
    endproperty
    a_led: assert property (p_led)
        else $error("led fail flag not set");

    property p_sync1_gate;
        @(posedge CLK) disable iff (!RESETN)
        ($past(cfg1_reg[ffc_pkg::CF1_HW_TORCH])
         && !$past(flags_reg[ffc_pkg::FLG_SYNC1]))
        |-> !flags_reg[ffc_pkg::FLG_SYNC1];
    endproperty
    a_sync1_gate: assert property (p_sync1_gate)
        else $error("sync1 flag set outside sync mode");

    property p_therm;
        @(posedge CLK) disable iff (!RESETN)
        (!therm_on && !flags_reg[ffc_pkg::FLG_THERMISTOR])
        |=> !flags_reg[ffc_pkg::FLG_THERMISTOR];
    endproperty
    a_therm: assert property (p_therm)
        else $error("thermistor flag set with mode off");

    property p_uv;
        @(posedge CLK) disable iff (!RESETN)
        (INPUT_UV_MON_EN && COND.input_uv)
        |=> flags_reg[ffc_pkg::FLG_INPUT_UV];
    endproperty
    a_uv: assert property (p_uv)
        else $error("input undervoltage flag not set");

    property p_torch_clear;
        @(posedge CLK) disable iff (!RESETN)
        (FLASH_DONE && !(REQ.wr && sel_cfg1)) |=> ##1 !HW_TORCH_EN;
    endproperty
    a_torch_clear: assert property (p_torch_clear)
        else $error("hardware torch not cleared after flash");

    property p_trig;
        @(posedge CLK) disable iff (!RESETN)
        !cfg1_reg[ffc_pkg::CF1_TRIG_EN] |=> !FLASH_TRIGGER;
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger passed while disabled");

    property p_unused;
        @(posedge CLK) disable iff (!RESETN)
        cfg2_reg[7:5] == 3'h0 && cfg1_reg[1:0] == 2'h0;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused config bit set");

    property p_shdn;
        @(posedge CLK) disable iff (!RESETN)
        (ev_uv && cfg2_reg[ffc_pkg::CF2_INPUT_UV_SHDN])
        |=> FORCE_SHUTDOWN && !FORCE_TORCH;
    endproperty
    a_shdn: assert property (p_shdn)
        else $error("input undervoltage did not force shutdown");

    property p_thermal;
        @(posedge CLK) disable iff (!RESETN)
        COND.thermal |=> flags_reg[ffc_pkg::FLG_THERMAL];
    endproperty
    a_thermal: assert property (p_thermal)
        else $error("thermal shutdown flag not set");

    property p_sync1_set;
        @(posedge CLK) disable iff (!RESETN)
        (sync1_mode && sync1_chg) |=> flags_reg[ffc_pkg::FLG_SYNC1];
    endproperty
    a_sync1_set: assert property (p_sync1_set)
        else $error("sync1 change not flagged in sync mode");

    property p_sync2_set;
        @(posedge CLK) disable iff (!RESETN)
        sync2_chg |=> flags_reg[ffc_pkg::FLG_SYNC2];
    endproperty
    a_sync2_set: assert property (p_sync2_set)
        else $error("sync2 change not flagged");

    property p_therm_set;
        @(posedge CLK) disable iff (!RESETN)
        (therm_on && COND.thermistor_low)
        |=> flags_reg[ffc_pkg::FLG_THERMISTOR];
    endproperty
    a_therm_set: assert property (p_therm_set)
        else $error("thermistor flag not set");

    property p_flash_uv;
        @(posedge CLK) disable iff (!RESETN)
        (FLASH_UV_MON_EN && COND.flash_uv)
        |=> flags_reg[ffc_pkg::FLG_FLASH_UV];
    endproperty
    a_flash_uv: assert property (p_flash_uv)
        else $error("flash undervoltage flag not set");

    property p_flash_uv_off;
        @(posedge CLK) disable iff (!RESETN)
        (!FLASH_UV_MON_EN && !flags_reg[ffc_pkg::FLG_FLASH_UV])
        |=> !flags_reg[ffc_pkg::FLG_FLASH_UV];
    endproperty
    a_flash_uv_off: assert property (p_flash_uv_off)
        else $error("flash undervoltage flag set with monitor off");

    property p_uv_off;
        @(posedge CLK) disable iff (!RESETN)
        (!INPUT_UV_MON_EN && !flags_reg[ffc_pkg::FLG_INPUT_UV])
        |=> !flags_reg[ffc_pkg::FLG_INPUT_UV];
    endproperty
    a_uv_off: assert property (p_uv_off)
        else $error("input undervoltage flag set with monitor off");

    property p_hw_torch_copy;
        @(posedge CLK) disable iff (!RESETN)
        1'h1 |=> HW_TORCH_EN == $past(cfg1_reg[ffc_pkg::CF1_HW_TORCH]);
    endproperty
    a_hw_torch_copy: assert property (p_hw_torch_copy)
        else $error("hardware torch output does not follow its bit");

    property p_alt_copy;
        @(posedge CLK) disable iff (!RESETN)
        1'h1 |=> ALTERNATE_EXTERNAL_TORCH ==
            $past(cfg2_reg[ffc_pkg::CF2_ALT_EXT_TORCH]);
    endproperty
    a_alt_copy: assert property (p_alt_copy)
        else $error("alternate torch output does not follow its bit");

    property p_trig_on;
        @(posedge CLK) disable iff (!RESETN)
        (cfg1_reg[ffc_pkg::CF1_TRIG_EN] && trig_level) |=> FLASH_TRIGGER;
    endproperty
    a_trig_on: assert property (p_trig_on)
        else $error("enabled trigger at active level not passed");

    property p_sync2_shdn;
        @(posedge CLK) disable iff (!RESETN)
        (sync2_act && cfg2_reg[ffc_pkg::CF2_SYNC2_SHDN])
        |=> FORCE_SHUTDOWN && !FORCE_TORCH;
    endproperty
    a_sync2_shdn: assert property (p_sync2_shdn)
        else $error("sync2 event did not force shutdown");

    property p_therm_shdn;
        @(posedge CLK) disable iff (!RESETN)
        (ev_therm && cfg2_reg[ffc_pkg::CF2_THERM_SHDN])
        |=> FORCE_SHUTDOWN && !FORCE_TORCH;
    endproperty
    a_therm_shdn: assert property (p_therm_shdn)
        else $error("thermistor trip did not force shutdown");

    property p_cfg2_write;
        @(posedge CLK) disable iff (!RESETN)
        (REQ.wr && sel_cfg2) |=>
        cfg2_reg == ($past(REQ.wdata) & ffc_pkg::FAULT_RESPONSE_CONFIG_MASK);
    endproperty
    a_cfg2_write: assert property (p_cfg2_write)
        else $error("response config write not masked and stored");
endmodule : ffc_bank
`default_nettype wire

// File: core/ffc_edge.sv
// Polarity-aware state-change detector for one sync input.
`timescale 1ns/1ps
`default_nettype none
module ffc_edge (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pin and polarity
    input wire logic pin,
    input wire logic active_high,
    // Outputs
    output logic active,
    output logic changed
);
    logic prev_reg;
    wire logic level = pin ~^ active_high;

    // The raw pin is remembered, not the adjusted level, so that a polarity
    // write never looks like a change of state. It is loaded during reset as
    // well, so a pin that idles high shows no false change after release.
    always_ff @(posedge clk) begin
        prev_reg <= pin;
    end

    assign active = level;
    assign changed = resetn && (pin ^ prev_reg);
endmodule : ffc_edge
`default_nettype wire

// File: core/ffc_pkg.sv
// Register map, field positions and carrier types of the fault flag bank.
package ffc_pkg;

    localparam logic [7:0] FAULT_FLAGS_ADDR = 8'hD0;
    localparam logic [7:0] INPUT_PIN_CONFIG_ADDR = 8'hE0;
    localparam logic [7:0] FAULT_RESPONSE_CONFIG_ADDR = 8'hF0;

    localparam int FLG_TIMEOUT = 0;
    localparam int FLG_THERMAL = 1;
    localparam int FLG_LED_FAIL = 2;
    localparam int FLG_SYNC1 = 3;
    localparam int FLG_SYNC2 = 4;
    localparam int FLG_THERMISTOR = 5;
    localparam int FLG_FLASH_UV = 6;
    localparam int FLG_INPUT_UV = 7;

    localparam int CF1_HW_TORCH = 7;
    localparam int CF1_SYNC2_POL = 6;
    localparam int CF1_SYNC1_POL = 5;
    localparam int CF1_THERMISTOR_MODE = 4;
    localparam int CF1_TRIG_POL = 3;
    localparam int CF1_TRIG_EN = 2;

    localparam int CF2_SYNC1_SHDN = 4;
    localparam int CF2_INPUT_UV_SHDN = 3;
    localparam int CF2_ALT_EXT_TORCH = 2;
    localparam int CF2_THERM_SHDN = 1;
    localparam int CF2_SYNC2_SHDN = 0;

    localparam logic [7:0] FAULT_FLAGS_RESET = 8'h00;
    localparam logic [7:0] INPUT_PIN_CONFIG_RESET = 8'h68;
    localparam logic [7:0] FAULT_RESPONSE_CONFIG_RESET = 8'h00;
    localparam logic [7:0] INPUT_PIN_CONFIG_MASK = 8'hFC;
    localparam logic [7:0] FAULT_RESPONSE_CONFIG_MASK = 8'h1F;

    // Raw fault conditions from the analog side, one per flag bit.
    typedef struct packed {
        logic input_uv;
        logic flash_uv;
        logic thermistor_low;
        logic sync2_pin;
        logic sync1_pin;
        logic led_fail;
        logic thermal;
        logic timeout;
    } ffc_cond_t;

    // Register access strobe group from the serial bus engine.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ffc_req_t;

endpackage : ffc_pkg

// File: verification/ffc_host.sv
// Host model that issues single-byte register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module ffc_host (
    // Clock
    input wire logic clk,
    // Register access
    output var ffc_pkg::ffc_req_t req,
    input wire logic [7:0] rdata
);
    initial req = '0;

    // Idle address and data are inverted so that stale values never match.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(negedge clk);
        req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(negedge clk);
        d = rdata;
        req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 8'hFF};
    endtask : rd
endmodule : ffc_host
`default_nettype wire

// File: verification/flash_fault_flags_config_bench.sv
// Self-checking bench for the fault flag and configuration bank.
`timescale 1ns/1ps
`default_nettype none
module flash_fault_flags_config_bench;
    logic clk;
    logic resetn = 1'h0;
    ffc_pkg::ffc_req_t req;
    ffc_pkg::ffc_cond_t cnd = '0;
    logic in_uv_en = 1'h1;
    logic fl_uv_en = 1'h1;
    logic done = 1'h0;
    logic trig = 1'h0;
    wire logic [7:0] rdata;
    wire logic [5:0] outs;
    int n_errors = 0;
    int compares = 0;

    ffc_host host_u (.clk(clk), .req(req), .rdata(rdata));

    ffc_bank dut_u (
        .CLK(clk), .RESETN(resetn), .REQ(req), .RDATA(rdata),
        .COND(cnd), .INPUT_UV_MON_EN(in_uv_en),
        .FLASH_UV_MON_EN(fl_uv_en), .FLASH_DONE(done),
        .TRIGGER_PIN(trig), .FLASH_TRIGGER(outs[5]),
        .HW_TORCH_EN(outs[4]), .THERMISTOR_MODE(outs[3]),
        .ALTERNATE_EXTERNAL_TORCH(outs[2]), .FORCE_TORCH(outs[1]),
        .FORCE_SHUTDOWN(outs[0])
    );

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("Compares %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host_u.rd(a, v);
        check(v, exp);
    endtask : rd_chk

    // Lets a write land in the register and then in the output copies.
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask : settle

    task automatic t_reset;
        rd_chk(8'hE0, 8'h68);
        rd_chk(8'hF0, 8'h00);
        rd_chk(8'hD0, 8'h00);
        check({2'h0, outs}, 8'h00);
    endtask : t_reset

    task automatic t_masks;
        host_u.wr(8'hE0, 8'hFF);
        host_u.wr(8'hF0, 8'hFF);
        rd_chk(8'hE0, 8'hFC);
        rd_chk(8'hF0, 8'h1F);
        check({2'h0, outs}, 8'h1C);
        host_u.wr(8'hF0, 8'h00);
    endtask : t_masks

    task automatic t_flags;
        host_u.wr(8'hE0, 8'h78);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            cnd = 8'h01 << i;
            @(negedge clk);
            cnd = '0;
            rd_chk(8'hD0, 8'h01 << i);
            rd_chk(8'hD0, 8'h00);
        end
        // Monitors off, thermistor mode off and the shared pin as torch.
        host_u.wr(8'hE0, 8'hE8);
        in_uv_en = 1'h0;
        fl_uv_en = 1'h0;
        @(negedge clk);
        cnd = 8'hE8;
        @(negedge clk);
        cnd = '0;
        rd_chk(8'hD0, 8'h00);
        in_uv_en = 1'h1;
        fl_uv_en = 1'h1;
        @(negedge clk);
        done = 1'h1;
        @(negedge clk);
        done = 1'h0;
        rd_chk(8'hE0, 8'h68);
    endtask : t_flags

    task automatic t_trig;
        trig = 1'h1;
        settle();
        check({7'h00, outs[5]}, 8'h00);
        host_u.wr(8'hE0, 8'h6C);
        settle();
        check({7'h00, outs[5]}, 8'h01);
        trig = 1'h0;
        settle();
        check({7'h00, outs[5]}, 8'h00);
        host_u.wr(8'hE0, 8'h64);
        settle();
        check({7'h00, outs[5]}, 8'h01);
    endtask : t_trig

    task automatic t_force;
        int cbit[4] = '{3, 4, 5, 7};
        int rbit[4] = '{4, 0, 1, 3};
        host_u.wr(8'hE0, 8'h78);
        for (int k = 0; k < 8; k++) begin
            host_u.wr(8'hF0, k[0] ? (8'h01 << rbit[k/2]) : 8'h00);
            cnd = 8'h01 << cbit[k/2];
            settle();
            check({6'h00, outs[1:0]}, k[0] ? 8'h01 : 8'h02);
            cnd = '0;
            settle();
        end
        host_u.wr(8'hF0, 8'h00);
    endtask : t_force

    task automatic t_race;
        logic [7:0] v;
        rd_chk(8'hD0, 8'hB8);
        fork
            host_u.rd(8'hD0, v);
            begin
                @(negedge clk);
                cnd = 8'h01;
                @(negedge clk);
                cnd = '0;
            end
        join
        check(v, 8'h00);
        rd_chk(8'hD0, 8'h01);
    endtask : t_race

    // Sync pins idle low, so active-low polarity asserts them at once.
    task automatic t_polarity;
        host_u.wr(8'hE0, 8'h58);
        settle();
        check({6'h00, outs[1:0]}, 8'h02);
        rd_chk(8'hD0, 8'h00);
        host_u.wr(8'hF0, 8'h01);
        host_u.wr(8'hE0, 8'h18);
        settle();
        check({6'h00, outs[1:0]}, 8'h01);
        rd_chk(8'hD0, 8'h00);
    endtask : t_polarity

    initial begin
        repeat (10) @(negedge clk);
        resetn = 1'h1;
        t_reset();
        t_masks();
        t_flags();
        t_trig();
        t_force();
        t_race();
        t_polarity();
        tally_and_finish();
    end

    // A hang is cut short and counted against the run.
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule : flash_fault_flags_config_bench
`default_nettype wire
